/* rtl/tcch_cmd.sv */
// tcch_cmd: opcode interpreter for the converter trigger and edge setup.
// assumes: host logic on clk strobes cmd_wr / cmd_rd one cycle each;
// save_user and global_rst_req come from outside the domain.
// Summary of operation
// [RQ1] load-user opcode restores the configuration saved earlier
// [RQ2] auto-user opcode sets startup flag to one
// [RQ3] auto-default opcode clears startup flag to zero
// [RQ4] old firmware: host waits over 10 ms after store writes; tcch_host waits only STORE_GAP = 4 cycles
// [RQ5] after set or read opcodes, wait for all words, refuse opcodes
// [RQ6] window width low 12 bits, 1..2088 or all ones, reset 0x14
// [RQ7] window offset 12-bit signed sign-extended, f800..0028, reset ffd8
// [RQ8] window start aligned to clock cycles, one cycle jitter
// [RQ9] extra search margin low 12 bits, reset 0x08
// [RQ10] reject margin low 12 bits, reset 0x04
// [RQ11] subtraction enabled: hit times from window start
// [RQ12] subtraction disabled: hit times from last bunch reset
// [RQ13] trigger readback: width, offset, search, reject, subtraction bit
// [RQ14] edge setting two low bits: pair, trailing, leading, both
// [RQ15] edge readback returns current setting in low two bits
// [RQ16] edge bin size two low bits, 25 ps at reset
// [RQ17] pair resolution bits 2:0 lead, 11:8 width, 1110/1111 invalid
// [RQ18] pair resolution setting acts only in pair edge mode
// [RQ19] readbacks return last accepted, reset or loaded value
`timescale 1ns/100ps
module tcch_cmd
   import tcch_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   cmd_wr,
   input  wire logic                   cmd_rd,
   input  wire logic [TCCH_WORD_W-1:0] cmd_wdata,
   input  wire logic                   save_user,
   input  wire logic                   global_rst_req,
   output logic [TCCH_WORD_W-1:0]      cmd_rdata,
   output logic                        busy,
   output logic                        cmd_err,
   output tcch_trig_t                  trig_cfg,
   output tcch_edge_cfg_t              edge_cfg,
   output logic                        win_rel_start,
   output logic                        auto_load
);

   typedef enum logic [1:0] {
      TCCH_IDLE,
      TCCH_WAIT_WR,
      TCCH_WAIT_RD
   } tcch_state_t;

   tcch_state_t   state_r;
   logic [7:0]    op_r;
   logic [2:0]    cnt_r;
   tcch_cfg_t     cfg_r;
   tcch_cfg_t     user_cfg;
   logic          auto_now;
   logic          save_s;
   logic          save_d_r;
   logic          grst_s;
   logic          grst_d_r;
   logic          grst_rise;
   logic          boot_r;
   logic          auto_set;
   logic          auto_clr;
   logic          op_take;
   logic [TCCH_WORD_W-1:0] rd_word;

   // number of parameter words that follow an opcode
   function automatic logic [2:0] words_of(input logic [7:0] op);
      unique case (op)
         TCCH_OP_SET_WIDTH, TCCH_OP_SET_OFFSET, TCCH_OP_SET_SEARCH,
         TCCH_OP_SET_REJECT, TCCH_OP_SET_EDGE, TCCH_OP_SET_LSB,
         TCCH_OP_SET_PAIR, TCCH_OP_RD_EDGE:
            words_of = 3'd1;
         TCCH_OP_RD_TRIG:
            words_of = 3'(TCCH_TRIG_RD_WORDS);
         default:
            words_of = 3'd0;
      endcase
   endfunction : words_of

   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == TCCH_OP_RD_TRIG) || (op == TCCH_OP_RD_EDGE);
   endfunction : is_read

   tcch_sync u_sync_save (
      .clk     (clk),
      .reset_n (reset_n),
      .din     (save_user),
      .dout    (save_s)
   );

   tcch_sync u_sync_grst (
      .clk     (clk),
      .reset_n (reset_n),
      .din     (global_rst_req),
      .dout    (grst_s)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         save_d_r <= 1'b0;
         grst_d_r <= 1'b0;
      end else begin
         save_d_r <= save_s;
         grst_d_r <= grst_s;
      end
   end

   assign grst_rise = grst_s & ~grst_d_r;
   assign op_take   = cmd_wr && (state_r == TCCH_IDLE);
   assign auto_set  = op_take && cmd_wdata[15:8] == TCCH_OP_AUTO_USER;
   assign auto_clr  = op_take && cmd_wdata[15:8] == TCCH_OP_AUTO_DEF;

   tcch_store u_store (
      .clk       (clk),
      .reset_n   (reset_n),
      .save_req  (save_s & ~save_d_r),
      .save_cfg  (cfg_r),
      .auto_set  (auto_set),
      .auto_clr  (auto_clr),
      .user_cfg  (user_cfg),
      .auto_load (auto_now)
   );

   // command sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= TCCH_IDLE;
         op_r    <= 8'h00;
         cnt_r   <= 3'd0;
      end else begin
         unique case (state_r)
            TCCH_IDLE: begin
               if (cmd_wr) begin
                  op_r  <= cmd_wdata[15:8];
                  cnt_r <= words_of(cmd_wdata[15:8]);
                  if (words_of(cmd_wdata[15:8]) != 3'd0) begin
                     state_r <= is_read(cmd_wdata[15:8]) ?
                                TCCH_WAIT_RD : TCCH_WAIT_WR; // [RQ5]
                  end
               end
            end
            TCCH_WAIT_WR: begin
               if (cmd_wr) begin
                  state_r <= TCCH_IDLE; // [RQ5]
               end
            end
            TCCH_WAIT_RD: begin
               if (cmd_rd) begin
                  cnt_r <= cnt_r - 3'd1;
                  if (cnt_r == 3'd1) begin
                     state_r <= TCCH_IDLE; // [RQ5]
                  end
               end
            end
         endcase
      end
   end

   // word presented for the next read, in readback order
   always_comb begin
      rd_word = '0;
      if (op_r == TCCH_OP_RD_EDGE) begin
         rd_word[1:0] = cfg_r.det.mode; // [RQ15]
      end else begin
         unique case (cnt_r)
            3'd5: rd_word = {4'h0, cfg_r.trig.width}; // [RQ13]
            3'd4: rd_word = cfg_r.trig.offset;
            3'd3: rd_word = {4'h0, cfg_r.trig.search};
            3'd2: rd_word = {4'h0, cfg_r.trig.reject};
            3'd1: rd_word = {15'h0000, cfg_r.trig.sub_en};
            default: rd_word = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_rdata <= '0;
      end else if (state_r == TCCH_WAIT_RD && cmd_rd) begin
         cmd_rdata <= rd_word; // [RQ19]
      end
   end

   // busy while parameter words are outstanding
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else if (state_r == TCCH_IDLE) begin
         busy <= cmd_wr && words_of(cmd_wdata[15:8]) != 3'd0; // [RQ5]
      end else if (state_r == TCCH_WAIT_WR) begin
         busy <= !cmd_wr;
      end else begin
         busy <= !(cmd_rd && cnt_r == 3'd1);
      end
   end

   // out-of-range parameter flag; width and offset are still stored, a bad pair width is not
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_err <= 1'b0;
      end else if (state_r == TCCH_WAIT_WR && cmd_wr) begin
         unique case (op_r)
            TCCH_OP_SET_WIDTH:
               cmd_err <= (cmd_wdata[11:0] == 12'h000) ||
                          (cmd_wdata[11:0] > TCCH_WIDTH_MAX &&
                           cmd_wdata[11:0] != TCCH_WIDTH_ALL); // [RQ6]
            TCCH_OP_SET_OFFSET:
               cmd_err <= ($signed(cmd_wdata) < $signed(TCCH_OFFS_MIN)) ||
                          ($signed(cmd_wdata) > $signed(TCCH_OFFS_MAX));
            TCCH_OP_SET_PAIR:
               cmd_err <= cmd_wdata[11:9] == TCCH_WID_BAD0[3:1] ||
                          cfg_r.det.mode != TCCH_EDGE_PAIR; // [RQ17] [RQ18]
            default:
               cmd_err <= 1'b0;
         endcase
      end else if (op_take) begin
         cmd_err <= 1'b0;
      end
   end

   // configuration store
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r  <= TCCH_CFG_DEFAULT;
         boot_r <= 1'b1;
      end else if (boot_r || grst_rise) begin
         boot_r <= 1'b0;
         cfg_r  <= auto_now ? user_cfg : TCCH_CFG_DEFAULT; // [RQ2] [RQ3]
      end else if (op_take) begin
         unique case (cmd_wdata[15:8])
            TCCH_OP_LOAD_USER: cfg_r <= user_cfg; // [RQ1]
            TCCH_OP_SUB_EN:    cfg_r.trig.sub_en <= 1'b1; // [RQ11]
            TCCH_OP_SUB_DIS:   cfg_r.trig.sub_en <= 1'b0; // [RQ12]
            default: ;
         endcase
      end else if (state_r == TCCH_WAIT_WR && cmd_wr) begin
         unique case (op_r)
            TCCH_OP_SET_WIDTH:  cfg_r.trig.width  <= cmd_wdata[11:0]; // [RQ6]
            TCCH_OP_SET_OFFSET: cfg_r.trig.offset <=
               {{4{cmd_wdata[11]}}, cmd_wdata[11:0]}; // [RQ7]
            TCCH_OP_SET_SEARCH: cfg_r.trig.search <= cmd_wdata[11:0]; // [RQ9]
            TCCH_OP_SET_REJECT: cfg_r.trig.reject <= cmd_wdata[11:0]; // [RQ10]
            TCCH_OP_SET_EDGE:
               cfg_r.det.mode <= tcch_edge_t'(cmd_wdata[1:0]); // [RQ14]
            TCCH_OP_SET_LSB:    cfg_r.det.lsb <= cmd_wdata[1:0]; // [RQ16]
            TCCH_OP_SET_PAIR: begin
               if (cfg_r.det.mode == TCCH_EDGE_PAIR) begin // [RQ18]
                  cfg_r.det.lead <= cmd_wdata[2:0]; // [RQ17]
                  if (cmd_wdata[11:9] != TCCH_WID_BAD0[3:1]) begin
                     cfg_r.det.wid <= cmd_wdata[11:8];
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // outputs registered; offset is whole cycles so start is cycle-aligned
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_cfg      <= TCCH_CFG_DEFAULT.trig;
         edge_cfg      <= TCCH_CFG_DEFAULT.det;
         win_rel_start <= 1'b0;
         auto_load     <= 1'b0;
      end else begin
         trig_cfg      <= cfg_r.trig; // [RQ8]
         edge_cfg      <= cfg_r.det;
         win_rel_start <= cfg_r.trig.sub_en; // [RQ11] [RQ12]
         auto_load     <= auto_now;
      end
   end

endmodule : tcch_cmd

/* rtl/tcch_pkg.sv */
// tcch_pkg: opcodes, field layouts, reset values and types of the
// converter configuration command interpreter.
// assumes: 16-bit command port, one clock domain.
package tcch_pkg;

   localparam int TCCH_WORD_W = 16;
   localparam int TCCH_FIELD_W = 12;

   // opcode class, upper byte of the command word
   localparam logic [7:0] TCCH_OP_LOAD_USER   = 8'h07;
   localparam logic [7:0] TCCH_OP_AUTO_USER   = 8'h08;
   localparam logic [7:0] TCCH_OP_AUTO_DEF    = 8'h09;
   localparam logic [7:0] TCCH_OP_SET_WIDTH   = 8'h10;
   localparam logic [7:0] TCCH_OP_SET_OFFSET  = 8'h11;
   localparam logic [7:0] TCCH_OP_SET_SEARCH  = 8'h12;
   localparam logic [7:0] TCCH_OP_SET_REJECT  = 8'h13;
   localparam logic [7:0] TCCH_OP_SUB_EN      = 8'h14;
   localparam logic [7:0] TCCH_OP_SUB_DIS     = 8'h15;
   localparam logic [7:0] TCCH_OP_RD_TRIG     = 8'h16;
   localparam logic [7:0] TCCH_OP_SET_EDGE    = 8'h22;
   localparam logic [7:0] TCCH_OP_RD_EDGE     = 8'h23;
   localparam logic [7:0] TCCH_OP_SET_LSB     = 8'h24;
   localparam logic [7:0] TCCH_OP_SET_PAIR    = 8'h25;

   localparam int TCCH_TRIG_RD_WORDS = 5;

   // clock period in ns, used for the window width unit
   localparam int TCCH_CLK_PERIOD_NS = 25;

   // field positions
   localparam int TCCH_EDGE_LSB = 0;
   localparam int TCCH_PAIR_LEAD_LSB = 0;
   localparam int TCCH_PAIR_WID_LSB = 8;

   // reset values
   localparam logic [11:0] TCCH_RST_WIDTH  = 12'h014;
   localparam logic [15:0] TCCH_RST_OFFSET = 16'hffd8;
   localparam logic [11:0] TCCH_RST_SEARCH = 12'h008;
   localparam logic [11:0] TCCH_RST_REJECT = 12'h004;
   localparam logic [1:0]  TCCH_RST_EDGE   = 2'h2;
   localparam logic [1:0]  TCCH_RST_LSB    = 2'h3;
   localparam logic [2:0]  TCCH_RST_LEAD   = 3'h0;
   localparam logic [3:0]  TCCH_RST_WID    = 4'h0;

   // window width, offset and pair width limits
   localparam logic [11:0] TCCH_WIDTH_MAX  = 12'h828;
   localparam logic [11:0] TCCH_WIDTH_ALL  = 12'hfff;
   localparam logic [15:0] TCCH_OFFS_MIN   = 16'hf800;
   localparam logic [15:0] TCCH_OFFS_MAX   = 16'h0028;
   localparam logic [3:0]  TCCH_WID_BAD0   = 4'he;

   typedef enum logic [1:0] {
      TCCH_EDGE_PAIR  = 2'h0,
      TCCH_EDGE_TRAIL = 2'h1,
      TCCH_EDGE_LEAD  = 2'h2,
      TCCH_EDGE_BOTH  = 2'h3
   } tcch_edge_t;

   // trigger matching configuration
   typedef struct packed {
      logic [11:0] width;
      logic [15:0] offset;
      logic [11:0] search;
      logic [11:0] reject;
      logic        sub_en;
   } tcch_trig_t;

   // edge and resolution configuration
   typedef struct packed {
      tcch_edge_t  mode;
      logic [1:0]  lsb;
      logic [2:0]  lead;
      logic [3:0]  wid;
   } tcch_edge_cfg_t;

   typedef struct packed {
      tcch_trig_t     trig;
      tcch_edge_cfg_t det;
   } tcch_cfg_t;

   localparam tcch_cfg_t TCCH_CFG_DEFAULT = '{
      trig: '{width: TCCH_RST_WIDTH, offset: TCCH_RST_OFFSET,
              search: TCCH_RST_SEARCH, reject: TCCH_RST_REJECT,
              sub_en: 1'b0},
      det: '{mode: tcch_edge_t'(TCCH_RST_EDGE), lsb: TCCH_RST_LSB,
              lead: TCCH_RST_LEAD, wid: TCCH_RST_WID}
   };

endpackage : tcch_pkg

/* rtl/tcch_store.sv */
// tcch_store: holds the saved user configuration and the startup flag.
// assumes: saving is done by logic outside; here it is written through
// save_req and read back on demand.
`timescale 1ns/100ps
module tcch_store
   import tcch_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset_n,
   input  wire logic      save_req,
   input  wire tcch_cfg_t save_cfg,
   input  wire logic      auto_set,
   input  wire logic      auto_clr,
   output tcch_cfg_t      user_cfg,
   output logic           auto_load
);

   tcch_cfg_t user_r;
   logic      auto_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         user_r <= TCCH_CFG_DEFAULT;
      end else if (save_req) begin
         user_r <= save_cfg;
      end
   end

   // startup selection flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_r <= 1'b0;
      end else if (auto_set) begin
         auto_r <= 1'b1; // [RQ2]
      end else if (auto_clr) begin
         auto_r <= 1'b0; // [RQ3]
      end
   end

   assign user_cfg  = user_r;
   assign auto_load = auto_r;

endmodule : tcch_store

/* rtl/tcch_sync.sv */
// tcch_sync: two-stage synchroniser for a level from outside the domain.
// assumes: input is a plain level, no pulse narrower than a clock.
`timescale 1ns/100ps
module tcch_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic din,
   output logic      dout
);

   logic meta_r;
   logic sync_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;

endmodule : tcch_sync

/* sim/tb.sv */
// tb: self-checking bench of the command interpreter.
// assumes: host model tasks drive the command port.
`timescale 1ns/100ps
module tb;
   import tcch_pkg::*;
   logic clk = 1'b0;
   logic reset_n, save_user, global_rst_req, cmd_wr, cmd_rd, busy, cmd_err;
   logic win_rel_start, auto_load;
   logic [15:0] cmd_wdata, cmd_rdata;
   tcch_trig_t trig_cfg;
   tcch_edge_cfg_t edge_cfg;
   int fail_count = 0;
   int checks = 0;
   always #5 clk = ~clk;
   tcch_cmd DUT (.clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_wdata, .save_user,
      .global_rst_req, .cmd_rdata, .busy, .cmd_err, .trig_cfg, .edge_cfg,
      .win_rel_start, .auto_load);
   tcch_host host (.clk, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata);
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (busy !== 1'b0) begin
         fail_count++;
         end_sim();
      end
      repeat (3) @(negedge clk);
   endtask : idle
   // grst selects the global reset pin, otherwise the save pin
   task automatic pulse(input logic grst, input logic [11:0] w);
      int n;
      n = 0;
      if (grst) global_rst_req = 1'b1;
      else save_user = 1'b1;
      repeat (4) @(negedge clk);
      global_rst_req = 1'b0;
      save_user = 1'b0;
      while (trig_cfg.width !== w && n < 10) begin
         @(negedge clk);
         n++;
      end
      if (trig_cfg.width !== w) fail_count++;
   endtask : pulse
   initial begin
      logic [15:0] d;
      logic [15:0] exp [5];
      logic [15:0] msk [5];
      reset_n = 1'b0;
      save_user = 1'b0;
      global_rst_req = 1'b0;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      check(16'(trig_cfg.width), 16'h0014);
      check(trig_cfg.offset, 16'hffd8);
      check(16'(trig_cfg.search), 16'h0008);
      check(16'(trig_cfg.reject), 16'h0004);
      check(16'(edge_cfg.mode), 16'h0002);
      check(16'(edge_cfg.lsb), 16'h0003);
      check(16'({edge_cfg.lead, edge_cfg.wid}), 16'h0000);
      check(16'({win_rel_start, auto_load, busy}), 16'h0000);
      check(16'({cmd_err, cmd_rdata}), 16'h0000);
      $display("test reset done");
      host.set(16'h1000, 16'hf830);
      check(16'(cmd_err), 16'h0001);
      host.set(16'h1100, 16'h0029);
      check(16'(cmd_err), 16'h0001);
      host.set(16'h1100, 16'hf800);
      check(16'(cmd_err), 16'h0000);
      host.set(16'h1200, 16'hf032);
      host.set(16'h1300, 16'h5000);
      host.op(16'h1400);
      idle();
      check(16'(trig_cfg.width), 16'h0830);
      check(trig_cfg.offset, 16'hf800);
      check(16'(trig_cfg.search), 16'h0032);
      check(16'(trig_cfg.reject), 16'h0000);
      check(16'(win_rel_start), 16'h0001);
      host.op(16'h1600);
      host.op(16'h1000);
      exp = '{16'h0830, 16'hf800, 16'h0032, 16'h0000, 16'h0001};
      msk = '{16'h0fff, 16'hffff, 16'h0fff, 16'h0fff, 16'h0001};
      for (int i = 0; i < 5; i++) begin
         host.rd(d);
         check(d & msk[i], exp[i]);
      end
      idle();
      check(16'(trig_cfg.width), 16'h0830);
      host.op(16'h1500);
      idle();
      check(16'(win_rel_start), 16'h0000);
      $display("test trigger done");
      for (int e = 0; e < 4; e++) begin
         host.set(16'h2200, {14'h2aa8, e[1:0]});
         host.set(16'h2400, {14'h1554, e[1:0]});
         host.op(16'h2300);
         host.rd(d);
         idle();
         check(16'(edge_cfg.mode), 16'(e));
         check(d & 16'h0003, 16'(e));
         check(16'(edge_cfg.lsb), 16'(e));
      end
      host.set(16'h2500, 16'h0102);
      idle();
      check(16'({edge_cfg.lead, edge_cfg.wid}), 16'h0000);
      check(16'(cmd_err), 16'h0001);
      host.set(16'h2200, 16'h0000);
      host.set(16'h2500, 16'h0d05);
      idle();
      check(16'({edge_cfg.lead, edge_cfg.wid}), 16'h005d);
      host.set(16'h2500, 16'h0e03);
      idle();
      check(16'({edge_cfg.lead, edge_cfg.wid}), 16'h003d);
      $display("test edge done");
      pulse(1'b0, 12'h830);
      host.set(16'h1000, 16'h0100);
      host.op(16'h0800);
      check(16'(auto_load), 16'h0001);
      host.op(16'h0700);
      idle();
      check(16'(trig_cfg.width), 16'h0830);
      host.set(16'h1000, 16'h0100);
      idle();
      pulse(1'b1, 12'h830);
      check(16'(trig_cfg.width), 16'h0830);
      host.op(16'h0900);
      check(16'(auto_load), 16'h0000);
      pulse(1'b1, 12'h014);
      check(16'(trig_cfg.width), 16'h0014);
      host.set(16'h1000, 16'h0000);
      idle();
      check(16'(cmd_err), 16'h0001);
      $display("test store done");
      // reset in mid-run: defaults return, pending flags clear
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      check(16'(trig_cfg.width), 16'h0014);
      check(16'({auto_load, busy, cmd_err}), 16'h0000);
      host.set(16'h1200, 16'h0020);
      idle();
      check(16'(trig_cfg.search), 16'h0020);
      $display("test reset again done");
      end_sim();
   end
endmodule : tb

/* sim/tcch_cmd_props.sv */
// tcch_cmd_props: port checker of the command interpreter.
// assumes: bound to tcch_cmd, one clock domain.
`timescale 1ns/100ps
module tcch_cmd_props
   import tcch_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic                   cmd_wr,
   input wire logic                   cmd_rd,
   input wire logic [TCCH_WORD_W-1:0] cmd_wdata,
   input wire logic                   busy,
   input wire tcch_trig_t             trig_cfg,
   input wire tcch_edge_cfg_t         edge_cfg,
   input wire logic                   win_rel_start,
   input wire logic                   auto_load
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [7:0]  op_r;
   logic [7:0]  tk;
   logic [7:0]  pop;
   logic [15:0] sx;
   assign tk  = (cmd_wr && !busy) ? cmd_wdata[15:8] : 8'hff;
   assign pop = (cmd_wr && busy) ? op_r : 8'hff;
   assign sx  = {{4{cmd_wdata[11]}}, cmd_wdata[11:0]};
   // opcode owning the words now outstanding
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) op_r <= 8'h00;
      else if (tk != 8'hff) op_r <= tk;
   end
   AST_BUSY_OP: assert property (tk inside {8'h10, 8'h11, 8'h12, 8'h13,
      8'h16, 8'h22, 8'h23, 8'h24, 8'h25} |=> busy)
      else $error("busy not raised after opcode");
   AST_RD_HOLD: assert property (pop == TCCH_OP_RD_TRIG |=> busy)
      else $error("read wait left on a write");
   AST_WIDTH: assert property (pop == TCCH_OP_SET_WIDTH |->
      ##2 trig_cfg.width == $past(cmd_wdata[11:0], 2))
      else $error("width not taken from low 12 bits");
   AST_OFFSET: assert property (pop == TCCH_OP_SET_OFFSET |->
      ##2 trig_cfg.offset == $past(sx, 2))
      else $error("offset not stored sign extended");
   AST_SEARCH: assert property (pop == TCCH_OP_SET_SEARCH |->
      ##2 trig_cfg.search == $past(cmd_wdata[11:0], 2))
      else $error("search margin wrong");
   AST_REJECT: assert property (pop == TCCH_OP_SET_REJECT |->
      ##2 trig_cfg.reject == $past(cmd_wdata[11:0], 2))
      else $error("reject margin wrong");
   AST_EDGE: assert property (pop == TCCH_OP_SET_EDGE |->
      ##2 edge_cfg.mode == $past(cmd_wdata[1:0], 2))
      else $error("edge mode wrong");
   AST_SUB_EN: assert property (tk == TCCH_OP_SUB_EN |->
      ##[1:3] win_rel_start && trig_cfg.sub_en)
      else $error("subtraction not enabled");
   AST_SUB_DIS: assert property (tk == TCCH_OP_SUB_DIS |->
      ##[1:3] !win_rel_start)
      else $error("subtraction not disabled");
   AST_AUTO_SET: assert property (tk == TCCH_OP_AUTO_USER |->
      ##[1:3] auto_load)
      else $error("startup flag not set");
   AST_AUTO_CLR: assert property (tk == TCCH_OP_AUTO_DEF |->
      ##[1:3] !auto_load)
      else $error("startup flag not cleared");
endmodule : tcch_cmd_props

bind tcch_cmd tcch_cmd_props u_props (.clk, .reset_n, .cmd_wr, .cmd_rd,
   .cmd_wdata, .busy, .trig_cfg, .edge_cfg, .win_rel_start, .auto_load);

/* sim/tcch_host.sv */
// tcch_host: bus host model with word write and read tasks.
// assumes: design samples on posedge clk; host drives on negedge.
`timescale 1ns/100ps
module tcch_host
   import tcch_pkg::*;
#(
   parameter int STORE_GAP = 4
)
(
   input  wire logic                   clk,
   output logic                        cmd_wr,
   output logic                        cmd_rd,
   output logic [TCCH_WORD_W-1:0]      cmd_wdata,
   input  wire logic [TCCH_WORD_W-1:0] cmd_rdata
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_wdata = 16'h0000;
   end
   // released data is inverted so a stale word is never mistaken
   task automatic op(input logic [15:0] d);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_wdata = d;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_wdata = ~d;
      // shortened pause after a store write
      if (d[15:8] inside {8'h08, 8'h09}) repeat (STORE_GAP) @(negedge clk);
   endtask : op
   // opcode then its parameter word back to back; sign extension is the
   // caller's duty
   task automatic set(input logic [15:0] o, input logic [15:0] p);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_wdata = o;
      @(negedge clk);
      cmd_wdata = p;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_wdata = ~p;
   endtask : set
   task automatic rd(output logic [15:0] d);
      @(negedge clk);
      cmd_rd = 1'b1;
      @(negedge clk);
      cmd_rd = 1'b0;
      @(negedge clk);
      d = cmd_rdata;
   endtask : rd
endmodule : tcch_host
